// >>> logic/drg_cfg.svh
// What this block does
// - check driver ready on start when enabled
// - ready at start: pulses begin at once
// - not ready: hold start, go when ready
// - three seconds not ready: abandon, alarm 6Fh
// - enabled: ready needs idle, no alarm, driver
// - disabled: ready needs idle, no alarm only
// - enable 0/1, effective after save and reset
// - reset loads saved value, else factory default; power-on clears saved value
// - writable immediately, read only in programs
`ifndef DRG_CFG_SVH
`define DRG_CFG_SVH

`define DRG_CLK_HZ          25000000
`define DRG_TIMEOUT_MS      3000
`define DRG_TIMEOUT_CYCLES  (`DRG_TIMEOUT_MS * (`DRG_CLK_HZ / 1000))
`define DRG_COUNT_W         27

`define DRG_ALARM_CODE      8'h6F
`define DRG_FACTORY_ENABLE  1'b0

`define DRG_CTRL_ADDR       32'h0000_0000
`define DRG_STATUS_ADDR     32'h0000_0004
`define DRG_IRQ_STAT_ADDR   32'h0000_0008
`define DRG_IRQ_MASK_ADDR   32'h0000_000C

`define DRG_CTRL_ENABLE_BIT 0
`define DRG_CTRL_SAVE_BIT   1
`define DRG_CTRL_CLEAR_BIT  2

`define DRG_ST_ACTIVE_BIT   0
`define DRG_ST_SAVED_BIT    1
`define DRG_ST_PEND_BIT     2
`define DRG_ST_ALARM_BIT    3
`define DRG_ST_DRDY_BIT     4
`define DRG_ST_READY_BIT    5
`define DRG_ST_CODE_LSB     8

`define DRG_IRQ_START_BIT   0
`define DRG_IRQ_ALARM_BIT   1
`define DRG_IRQ_W           2

`endif

// >>> logic/drg_pkg.sv
package drg_pkg;

    typedef enum logic [1:0] {
        GATE_IDLE = 2'b01,
        GATE_WAIT = 2'b10
    } gate_state_e;

    typedef enum logic [2:0] {
        SEL_NONE   = 3'h0,
        SEL_CTRL   = 3'h1,
        SEL_STATUS = 3'h2,
        SEL_IRQ_ST = 3'h3,
        SEL_IRQ_MK = 3'h4
    } reg_sel_e;

endpackage : drg_pkg

// >>> logic/saved_setting_store.sv
`timescale 1ns/1ps
`include "drg_cfg.svh"

module saved_setting_store (
    input  wire logic core_clk_i,
    input  wire logic por_b_i,
    input  wire logic save_i,
    input  wire logic value_i,
    output logic      value_o,
    output logic      valid_o
);

    logic value_reg;
    logic value_next;
    logic valid_reg;
    logic valid_next;

    always_comb begin
        value_next = value_reg;
        valid_next = valid_reg;
        if (save_i) begin
            value_next = value_i;
            valid_next = 1'b1;
        end
    end

    // survives system reset, cleared only at power-on
    always_ff @(posedge core_clk_i or negedge por_b_i) begin
        if (!por_b_i) begin
            value_reg <= `DRG_FACTORY_ENABLE;
            valid_reg <= 1'b0;
        end else begin
            value_reg <= value_next;
            valid_reg <= valid_next;
        end
    end

    assign value_o = value_reg;
    assign valid_o = valid_reg;

endmodule : saved_setting_store

// >>> logic/driver_ready_start_gate.sv
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "drg_cfg.svh"

module driver_ready_start_gate
    import drg_pkg::*;
#(
    parameter int         COUNT_W        = `DRG_COUNT_W,
    parameter int         TIMEOUT_CYCLES = `DRG_TIMEOUT_CYCLES,
    parameter logic       FACTORY_ENABLE = `DRG_FACTORY_ENABLE
) (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        por_b_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        start_req_i,
    input  wire logic        driver_ready_i,
    input  wire logic        moving_i,
    input  wire logic        program_running_i,
    input  wire logic        alarm_clear_i,
    output logic             pulse_start_o,
    output logic             pending_o,
    output logic             ready_o,
    output logic             remote_ready_o,
    output logic             alarm_o,
    output logic [7:0]       alarm_code_o,
    output logic             irq_o
);

    gate_state_e              state_reg;
    gate_state_e              state_next;
    logic [COUNT_W-1:0]       count_reg;
    logic [COUNT_W-1:0]       count_next;
    logic                     drdy_meta_reg;
    logic                     drdy_sync_reg;
    logic                     load_reg;
    logic                     load_next;
    logic                     enable_active_reg;
    logic                     enable_active_next;
    logic                     enable_written_reg;
    logic                     enable_written_next;
    logic                     save_reg;
    logic                     save_next;
    logic                     alarm_reg;
    logic                     alarm_next;
    logic [7:0]               alarm_code_reg;
    logic [7:0]               alarm_code_next;
    logic                     pulse_reg;
    logic                     pulse_next;
    logic                     ready_reg;
    logic                     ready_next;
    logic                     remote_ready_reg;
    logic [`DRG_IRQ_W-1:0]    irq_status_reg;
    logic [`DRG_IRQ_W-1:0]    irq_status_next;
    logic [`DRG_IRQ_W-1:0]    irq_mask_reg;
    logic [`DRG_IRQ_W-1:0]    irq_mask_next;
    logic                     irq_reg;
    logic                     irq_next;
    logic                     ap_write_reg;
    logic                     ap_write_next;
    reg_sel_e                 ap_sel_reg;
    reg_sel_e                 ap_sel_next;
    logic [31:0]              rdata_reg;
    logic [31:0]              rdata_next;
    logic                     saved_value;
    logic                     saved_valid;
    logic                     ap_take;
    reg_sel_e                 ap_sel;
    logic                     wr_ctrl;
    logic                     wr_mask;
    logic                     rd_irq;
    logic                     start_evt;
    logic                     alarm_set;
    logic                     clear_req;
    logic                     idle_next;
    logic [31:0]              status_word;

    localparam logic [COUNT_W-1:0] TERMINAL =
        COUNT_W'(TIMEOUT_CYCLES - 1);

    function automatic reg_sel_e decode_sel(input logic [31:0] a);
        reg_sel_e s;
        s = SEL_NONE;
        unique case ({a[31:2], 2'b00})
            `DRG_CTRL_ADDR:     s = SEL_CTRL;
            `DRG_STATUS_ADDR:   s = SEL_STATUS;
            `DRG_IRQ_STAT_ADDR: s = SEL_IRQ_ST;
            `DRG_IRQ_MASK_ADDR: s = SEL_IRQ_MK;
            default:            s = SEL_NONE;
        endcase
        return s;
    endfunction : decode_sel

    saved_setting_store u_store (
        .core_clk_i (core_clk_i),
        .por_b_i    (por_b_i),
        .save_i     (save_reg),
        .value_i    (enable_written_reg),
        .value_o    (saved_value),
        .valid_o    (saved_valid)
    );

    // driver ready pin synchroniser
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drdy_meta_reg <= 1'b0;
            drdy_sync_reg <= 1'b0;
        end else begin
            drdy_meta_reg <= driver_ready_i;
            drdy_sync_reg <= drdy_meta_reg;
        end
    end

    // bus address phase decode
    always_comb begin
        ap_take       = hsel_i && hready_i && htrans_i[1];
        ap_sel        = decode_sel(haddr_i);
        ap_write_next = ap_take && hwrite_i;
        ap_sel_next   = ap_take ? ap_sel : SEL_NONE;
        rd_irq        = ap_take && !hwrite_i && (ap_sel == SEL_IRQ_ST);
        wr_ctrl       = ap_write_reg && (ap_sel_reg == SEL_CTRL);
        wr_mask       = ap_write_reg && (ap_sel_reg == SEL_IRQ_MK);
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`DRG_ST_ACTIVE_BIT] = enable_active_reg;
        status_word[`DRG_ST_SAVED_BIT]  = saved_valid;
        status_word[`DRG_ST_PEND_BIT]   = state_reg[1];
        status_word[`DRG_ST_ALARM_BIT]  = alarm_reg;
        status_word[`DRG_ST_DRDY_BIT]   = drdy_sync_reg;
        status_word[`DRG_ST_READY_BIT]  = ready_reg;
        status_word[`DRG_ST_CODE_LSB +: 8] = alarm_code_reg;
        rdata_next = rdata_reg;
        if (ap_take && !hwrite_i) begin
            rdata_next = 32'h0000_0000;
            unique case (ap_sel)
                SEL_CTRL: begin
                    rdata_next[`DRG_CTRL_ENABLE_BIT] = enable_written_reg;
                end
                SEL_STATUS: begin
                    rdata_next = status_word;
                end
                SEL_IRQ_ST: begin
                    rdata_next[`DRG_IRQ_W-1:0] = irq_status_reg;
                end
                SEL_IRQ_MK: begin
                    rdata_next[`DRG_IRQ_W-1:0] = irq_mask_reg;
                end
                SEL_NONE: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // settings: active copy, written copy, save strobe
    always_comb begin
        load_next           = 1'b0;
        enable_active_next  = enable_active_reg;
        enable_written_next = enable_written_reg;
        save_next           = 1'b0;
        if (load_reg) begin
            enable_active_next  = saved_valid ? saved_value
                                              : FACTORY_ENABLE;
            enable_written_next = enable_active_next;
        end
        if (wr_ctrl && !program_running_i) begin
            enable_written_next = hwdata_i[`DRG_CTRL_ENABLE_BIT];
            save_next = hwdata_i[`DRG_CTRL_SAVE_BIT];
        end
    end

    // start gate state machine
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        pulse_next = 1'b0;
        alarm_set  = 1'b0;
        start_evt  = start_req_i && !alarm_reg && !load_reg;
        unique case (state_reg)
            GATE_IDLE: begin
                count_next = '0;
                if (start_evt) begin
                    if (!enable_active_reg || drdy_sync_reg) begin
                        pulse_next = 1'b1;
                    end else begin
                        state_next = GATE_WAIT;
                    end
                end
            end
            GATE_WAIT: begin
                if (drdy_sync_reg) begin
                    pulse_next = 1'b1;
                    state_next = GATE_IDLE;
                end else if (count_reg == TERMINAL) begin
                    alarm_set  = 1'b1;
                    state_next = GATE_IDLE;
                end else begin
                    count_next = count_reg + COUNT_W'(1);
                end
            end
        endcase
    end

    // alarm, ready outputs, interrupts
    always_comb begin
        clear_req = alarm_clear_i ||
                    (wr_ctrl && hwdata_i[`DRG_CTRL_CLEAR_BIT]);
        alarm_next = alarm_set || (alarm_reg && !clear_req);
        alarm_code_next = alarm_next ? `DRG_ALARM_CODE : 8'h00;
        idle_next  = !moving_i && !program_running_i && !alarm_next &&
                     (state_next == GATE_IDLE) && !load_reg;
        ready_next = idle_next && (!enable_active_next || drdy_sync_reg);
        irq_status_next = irq_status_reg;
        if (rd_irq) begin
            irq_status_next = '0;
        end
        if (pulse_next) begin
            irq_status_next[`DRG_IRQ_START_BIT] = 1'b1;
        end
        if (alarm_set) begin
            irq_status_next[`DRG_IRQ_ALARM_BIT] = 1'b1;
        end
        irq_mask_next = irq_mask_reg;
        if (wr_mask) begin
            irq_mask_next = hwdata_i[`DRG_IRQ_W-1:0];
        end
        irq_next = |(irq_status_next & irq_mask_next);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg          <= GATE_IDLE;
            count_reg          <= '0;
            load_reg           <= 1'b1;
            enable_active_reg  <= `DRG_FACTORY_ENABLE;
            enable_written_reg <= `DRG_FACTORY_ENABLE;
            save_reg           <= 1'b0;
            alarm_reg          <= 1'b0;
            alarm_code_reg     <= 8'h00;
            pulse_reg          <= 1'b0;
            ready_reg          <= 1'b0;
            remote_ready_reg   <= 1'b0;
            irq_status_reg     <= '0;
            irq_mask_reg       <= '0;
            irq_reg            <= 1'b0;
            ap_write_reg       <= 1'b0;
            ap_sel_reg         <= SEL_NONE;
            rdata_reg          <= 32'h0000_0000;
        end else begin
            state_reg          <= state_next;
            count_reg          <= count_next;
            load_reg           <= load_next;
            enable_active_reg  <= enable_active_next;
            enable_written_reg <= enable_written_next;
            save_reg           <= save_next;
            alarm_reg          <= alarm_next;
            alarm_code_reg     <= alarm_code_next;
            pulse_reg          <= pulse_next;
            ready_reg          <= ready_next;
            remote_ready_reg   <= ready_next;
            irq_status_reg     <= irq_status_next;
            irq_mask_reg       <= irq_mask_next;
            irq_reg            <= irq_next;
            ap_write_reg       <= ap_write_next;
            ap_sel_reg         <= ap_sel_next;
            rdata_reg          <= rdata_next;
        end
    end

    // zero wait state, always okay
    logic hreadyout_reg;
    logic hresp_reg;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    assign hreadyout_o    = hreadyout_reg;
    assign hresp_o        = hresp_reg;
    assign hrdata_o       = rdata_reg;
    assign pulse_start_o  = pulse_reg;
    assign pending_o      = state_reg[1];
    assign ready_o        = ready_reg;
    assign remote_ready_o = remote_ready_reg;
    assign alarm_o        = alarm_reg;
    assign alarm_code_o   = alarm_code_reg;
    assign irq_o          = irq_reg;

endmodule : driver_ready_start_gate

// >>> sim/drg_properties.sv
`timescale 1ns/1ps

module drg_checker #(
    parameter int TIMEOUT_CYCLES = 50
) (
    input wire logic       core_clk_i,
    input wire logic       rst_b_i,
    input wire logic       start_req_i,
    input wire logic       moving_i,
    input wire logic       program_running_i,
    input wire logic       alarm_clear_i,
    input wire logic       pulse_start_o,
    input wire logic       pending_o,
    input wire logic       ready_o,
    input wire logic       remote_ready_o,
    input wire logic       alarm_o,
    input wire logic [7:0] alarm_code_o,
    input wire logic       hreadyout_o,
    input wire logic       hresp_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    logic [31:0] pend_cnt_reg;
    logic [31:0] pend_cnt_next;

    // consecutive cycles spent pending
    always_comb pend_cnt_next = pending_o ? pend_cnt_reg + 32'h1 : 32'h0;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) pend_cnt_reg <= 32'h0;
        else pend_cnt_reg <= pend_cnt_next;
    end

    sequence pend_over;
        $fell(pending_o);
    endsequence
    sequence alarm_up;
        $rose(alarm_o);
    endsequence

    chk_code_alarm: assert property (
        alarm_code_o == (alarm_o ? 8'h6F : 8'h00))
        else $error("alarm code does not follow alarm");
    chk_alarm_timing: assert property (
        alarm_up |-> pend_cnt_reg == TIMEOUT_CYCLES)
        else $error("alarm raised at wrong wait length");
    chk_pend_bound: assert property (
        pend_cnt_reg <= TIMEOUT_CYCLES)
        else $error("pending outlived the timeout");
    chk_pend_exit: assert property (
        pend_over |-> pulse_start_o || alarm_o || $past(pulse_start_o))
        else $error("pending ended without pulse or alarm");
    chk_pulse_cause: assert property (
        pulse_start_o |-> $past(start_req_i) || $past(pending_o))
        else $error("pulse without start request");
    chk_pulse_single: assert property (
        pulse_start_o |=> !pulse_start_o)
        else $error("pulse longer than one cycle");
    chk_remote_same: assert property (
        remote_ready_o == ready_o)
        else $error("remote ready differs from ready");
    chk_ready_cause: assert property (
        $rose(ready_o) |-> !alarm_o && !$past(moving_i) &&
                           !$past(program_running_i))
        else $error("ready rose while busy");
    chk_alarm_blocks: assert property (
        alarm_o |-> !ready_o && !remote_ready_o)
        else $error("ready while alarm latched");
    chk_alarm_latch: assert property (
        $fell(alarm_o) |-> $past(alarm_clear_i) || $past(alarm_clear_i, 2))
        else $error("alarm dropped without clear");
    chk_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
endmodule : drg_checker

bind driver_ready_start_gate drg_checker #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) drg_checker_inst (
    .core_clk_i, .rst_b_i, .start_req_i, .moving_i, .program_running_i,
    .alarm_clear_i, .pulse_start_o, .pending_o, .ready_o, .remote_ready_o,
    .alarm_o, .alarm_code_o, .hreadyout_o, .hresp_o
);

// >>> sim/driver_ready_model.sv
`timescale 1ns/1ps

module driver_ready_model (
    input  wire logic       core_clk_i,
    input  wire logic       power_i,
    input  wire logic [7:0] delay_i,
    output logic            ready_o
);
    logic [7:0] cnt;

    // ready on the delay_i+1 th clock edge with power, never for delay FF
    always @(posedge core_clk_i) begin
        if (!power_i) begin
            cnt <= 8'h00;
            ready_o <= 1'b0;
        end else if (cnt != delay_i) cnt <= cnt + 8'h01;
        else if (delay_i != 8'hFF) ready_o <= 1'b1;
    end
endmodule : driver_ready_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "drg_cfg.svh"

module tb_top;
    localparam int TO = 50;
    logic        core_clk_i = 1'b0, rst_b_i = 1'b0, por_b_i = 1'b0;
    logic        hsel_i = 1'b0, hwrite_i = 1'b0, hready_i;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic        start_req_i = 1'b0, moving_i = 1'b0;
    logic        program_running_i = 1'b0, alarm_clear_i = 1'b0;
    logic        hreadyout_o, hresp_o, driver_ready_i, pulse_start_o;
    logic        pending_o, ready_o, remote_ready_o, alarm_o, irq_o;
    logic [7:0]  alarm_code_o, drv_delay = 8'h00;
    logic        drv_power = 1'b0;
    int          errors = 0, check_count = 0, cyc = 0;

    assign hready_i = hreadyout_o;
    always #20 core_clk_i = ~core_clk_i;

    driver_ready_start_gate #(
        .TIMEOUT_CYCLES (TO)
    ) driver_ready_start_gate_inst (
        .core_clk_i        (core_clk_i),
        .rst_b_i           (rst_b_i),
        .por_b_i           (por_b_i),
        .hsel_i            (hsel_i),
        .haddr_i           (haddr_i),
        .htrans_i          (htrans_i),
        .hwrite_i          (hwrite_i),
        .hsize_i           (hsize_i),
        .hwdata_i          (hwdata_i),
        .hready_i          (hready_i),
        .hreadyout_o       (hreadyout_o),
        .hresp_o           (hresp_o),
        .hrdata_o          (hrdata_o),
        .start_req_i       (start_req_i),
        .driver_ready_i    (driver_ready_i),
        .moving_i          (moving_i),
        .program_running_i (program_running_i),
        .alarm_clear_i     (alarm_clear_i),
        .pulse_start_o     (pulse_start_o),
        .pending_o         (pending_o),
        .ready_o           (ready_o),
        .remote_ready_o    (remote_ready_o),
        .alarm_o           (alarm_o),
        .alarm_code_o      (alarm_code_o),
        .irq_o             (irq_o)
    );
    driver_ready_model driver_ready_model_inst (.core_clk_i,
        .power_i(drv_power), .delay_i(drv_delay), .ready_o(driver_ready_i));

    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge core_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
    endtask : bus

    task automatic do_rst(input logic por);
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        por_b_i <= !por;
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        por_b_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask : do_rst

    task automatic start_cmd;
        @(posedge core_clk_i);
        start_req_i <= 1'b1;
        @(posedge core_clk_i);
        start_req_i <= 1'b0;
        #1;
    endtask : start_cmd

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
    endtask : wait_hi

    task automatic t_disabled;
        chk("ready no driver", 1, ready_o);
        bus(`DRG_STATUS_ADDR, 0, 0);
        chk("status", 32'h20, rd & 32'hFFFF);
        start_cmd;
        chk("pulse", 1, pulse_start_o);
        $display("test disabled done");
    endtask : t_disabled

    task automatic t_enable;
        bus(`DRG_CTRL_ADDR, 1, 32'h3);
        bus(`DRG_STATUS_ADDR, 0, 0);
        chk("active pre reset", 32'h2, rd & 32'h3);
        do_rst(0);
        bus(`DRG_STATUS_ADDR, 0, 0);
        chk("active", 32'h3, rd & 32'h3);
        chk("ready no driver", 0, ready_o);
        start_cmd;
        chk("pending", 1, pending_o);
        chk("no pulse", 0, pulse_start_o);
        @(posedge core_clk_i);
        drv_delay <= 8'd10;
        drv_power <= 1'b1;
        wait_hi(pulse_start_o, 30);
        chk("late pulse", 1, pulse_start_o);
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("ready driver", 1, ready_o);
        @(posedge core_clk_i);
        moving_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("ready moving", 0, ready_o);
        @(posedge core_clk_i);
        moving_i <= 1'b0;
        start_cmd;
        chk("pulse now", 1, pulse_start_o);
        @(posedge core_clk_i);
        #1;
        chk("pulse width", 0, pulse_start_o);
        chk("irq masked", 0, irq_o);
        bus(`DRG_IRQ_STAT_ADDR, 0, 0);
        chk("start flag", 1, rd & 32'h1);
        bus(`DRG_IRQ_STAT_ADDR, 0, 0);
        chk("flag cleared", 0, rd & 32'h3);
        $display("test enabled done");
    endtask : t_enable

    task automatic t_timeout;
        bus(`DRG_IRQ_MASK_ADDR, 1, 32'h2);
        drv_power <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        start_cmd;
        repeat (TO - 3) @(posedge core_clk_i);
        #1;
        chk("no early alarm", 0, alarm_o);
        wait_hi(alarm_o, 10);
        chk("alarm", 1, alarm_o);
        chk("code", 32'h6F, alarm_code_o);
        chk("pulse none", 0, pulse_start_o | pending_o);
        @(posedge core_clk_i);
        drv_power <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        #1;
        chk("irq", 1, irq_o);
        chk("ready in alarm", 0, ready_o);
        start_cmd;
        chk("start refused", 0, pulse_start_o | pending_o);
        bus(`DRG_IRQ_STAT_ADDR, 0, 0);
        chk("alarm flag", 32'h2, rd & 32'h3);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("irq cleared", 0, irq_o);
        chk("alarm held", 1, alarm_o);
        @(posedge core_clk_i);
        alarm_clear_i <= 1'b1;
        @(posedge core_clk_i);
        alarm_clear_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("alarm gone", 0, alarm_o | alarm_code_o);
        chk("ready back", 1, ready_o);
        $display("test timeout done");
    endtask : t_timeout

    task automatic t_program;
        @(posedge core_clk_i);
        program_running_i <= 1'b1;
        bus(`DRG_CTRL_ADDR, 1, 32'h2);
        bus(`DRG_CTRL_ADDR, 0, 0);
        chk("ctrl in program", 1, rd & 32'h1);
        program_running_i <= 1'b0;
        bus(32'h10, 0, 0);
        chk("unmapped", 0, rd);
        do_rst(0);
        bus(`DRG_STATUS_ADDR, 0, 0);
        chk("still enabled", 32'h3, rd & 32'h3);
        do_rst(1);
        bus(`DRG_STATUS_ADDR, 0, 0);
        chk("factory", 0, rd & 32'h3);
        $display("test program done");
    endtask : t_program

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test;
        end
    end

    initial begin
        do_rst(1);
        t_disabled;
        t_enable;
        t_timeout;
        t_program;
        stop_test;
    end
endmodule : tb_top
